// File: design/fixed_range_store.sv
/*
 * fixed-range store: eleven 64-bit words of eight type bytes each, with a
 * registered software read port and a combinational lookup of one byte.
 * assumes one clock mclk, asynchronous active-low reset and a clock enable.
 */
`timescale 1ns/1ps
`include "memtype_consts.svh"

module fixed_range_store
	import memtype_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [3:0] wr_idx,
	input wire logic [63:0] wr_data,
	input wire logic rd_en,
	input wire logic [3:0] rd_idx,
	output logic [63:0] rd_data,
	input wire logic [19:12] look_addr,
	output logic [7:0] look_type
);

	logic [63:0] mem_q [`FIX_REGS];
	logic [3:0] look_idx;
	logic [2:0] look_field;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `FIX_REGS; i++) begin
				mem_q[i] <= `RST_WORD;
			end
		end else if (ce && wr_en && wr_idx < 4'(`FIX_REGS)) begin
			mem_q[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= `RST_WORD;
		end else if (ce && rd_en) begin
			rd_data <= (rd_idx < 4'(`FIX_REGS)) ? mem_q[rd_idx] : `RST_WORD;
		end
	end

	// ****************************************
	// 64k, 16k and 4k sub-range selection
	// ****************************************
	always_comb begin
		look_idx = 4'h0;
		look_field = look_addr[18:16];
		if (look_addr[19] == 1'b0) begin
			look_idx = 4'h0;
			look_field = look_addr[18:16];
		end else if (look_addr[18] == 1'b0) begin
			look_idx = 4'h1 + {3'h0, look_addr[17]};
			look_field = look_addr[16:14];
		end else begin
			look_idx = 4'h3 + {1'b0, look_addr[17:15]};
			look_field = look_addr[14:12];
		end
		look_type = mem_q[look_idx][look_field*8 +: 8];
	end

endmodule

// File: design/memtype_consts.svh
/*
 * constants of the memory type resolver: register indices, field positions,
 * reserved-bit masks, reset values and type encodings.
 * assumes inclusion by bare name from the package and the design modules.
 */
`ifndef MEMTYPE_CONSTS_SVH
`define MEMTYPE_CONSTS_SVH

// ****************************************
// register indices on the port bus
// ****************************************
`define ADDR_DEFAULT_TYPE 8'h00
`define ADDR_FIX_FIRST 8'h01
`define ADDR_FIX_LAST 8'h0b
`define ADDR_VAR_FIRST 8'h10
`define ADDR_VAR_LAST 8'h1f

// ****************************************
// field positions
// ****************************************
`define TYPE_MSB 7
`define TYPE_LSB 0
`define FIXED_EN_BIT 10
`define ENABLE_BIT 11
`define VALID_BIT 11
`define FIELD_MSB 35
`define FIELD_LSB 12
`define FIELD_W 24
`define EXT_ZEROS 12
`define PAIR_COUNT 8
`define FIX_REGS 11

// ****************************************
// reserved-bit masks
// ****************************************
`define DEF_RSVD_MASK 64'hffff_ffff_ffff_f300
`define BASE_RSVD_MASK 64'hffff_fff0_0000_0f00
`define MASK_RSVD_MASK 64'hffff_fff0_0000_07ff

// ****************************************
// reset values and type encodings
// ****************************************
`define RST_WORD 64'h0000_0000_0000_0000
`define RST_FIELD 24'h00_0000
`define RST_TYPE 8'h00
`define TYPE_UNCACHED 8'h00
`define TYPE_COMBINING 8'h01
`define TYPE_THROUGH 8'h04
`define TYPE_PROTECTED 8'h05
`define TYPE_BACK 8'h06

`endif

// File: design/memtype_pkg.sv
/*
 * types shared by the memory type resolver and its fixed-range store.
 * assumes the constants header sits beside it.
 */
`include "memtype_consts.svh"

package memtype_pkg;

	typedef enum logic [7:0] {
		uncached_type = 8'h00,
		write_combining_type = 8'h01,
		write_through_type = 8'h04,
		write_protected_type = 8'h05,
		write_back_type = 8'h06
	} mem_kind_type;

	typedef logic [`FIELD_W-1:0] range_field_type;

endpackage

// File: design/memtype_resolver.sv
/*
 * memory type resolver: default, fixed and variable range registers on a
 * plain port bus, and a same-cycle lookup of the type of a physical address.
 * assumes a bus master with one-cycle strobes, read data taken one cycle
 * after the read strobe, and a lookup address stable on mclk.
 */
// Contract
// (R1) a variable pair matches only while its mask valid bit 11 is set
// (R2) writing a reserved bit of a base or mask register faults
// (R3) several matches all uncached, or uncached with write-back, give uncached
// (R4) software avoids other variable overlaps; result there is don't-care
// (R5) fixed-range type beats any variable match inside the first megabyte
// (R6) addresses left out by a discontinuous mask get the default type
// (R7) base and mask are 24-bit fields extended by twelve low zeros
// (R8) software sizes ranges as powers of two, aligned, at least 4 KB
// (R9) while globally disabled every access gets the default type
// (R10) enabled fixed ranges supply the type below 1 MB
// (R11) a single active variable match supplies its base type field
// (R12) no fixed and no variable match gives the default type
// (R13) reset clears every valid flag and the global enable
// (R14) software zeroes all range registers before programming types
// (R15) boot firmware leaves two variable pairs free
// (R16) match when address and mask equal base and mask
// (R17) base register bits 0 to 7 hold the pair's type
// (R18) default register bit 11 is the global enable
// (R19) default register bit 10 enables the fixed ranges
// (R20) types encode uncached 0, combining 1, through 4, protected 5, back 6
// (R21) eight pairs checked in parallel, result in the same cycle
`timescale 1ns/1ps
`include "memtype_consts.svh"

module memtype_resolver
	import memtype_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [63:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [63:0] reg_rdata,
	output logic general_protection_fault,
	input wire logic [35:0] lookup_addr,
	output logic [7:0] lookup_type
);

	// ****************************************
	// register state
	// ****************************************
	logic [7:0] def_type_q;
	logic fixed_range_enable_q;
	logic global_enable_q;
	range_field_type range_base_field_q [`PAIR_COUNT];
	logic [7:0] base_type_q [`PAIR_COUNT];
	range_field_type range_mask_field_q [`PAIR_COUNT];
	logic [`PAIR_COUNT-1:0] valid_q;
	logic [63:0] rdata_q;
	logic fix_sel_q;
	logic fault_q;
	logic [63:0] fix_rdata;
	logic [7:0] fix_type;
	logic wr_ok;
	logic wr_take;
	logic [2:0] wr_pair;

	// ****************************************
	// decode and legality helpers
	// ****************************************
	function automatic logic is_fix(input logic [7:0] a);
		return (a >= `ADDR_FIX_FIRST) && (a <= `ADDR_FIX_LAST);
	endfunction

	function automatic logic is_var(input logic [7:0] a);
		return (a >= `ADDR_VAR_FIRST) && (a <= `ADDR_VAR_LAST);
	endfunction

	function automatic logic legal_type(input logic [7:0] t);
		return (t == `TYPE_UNCACHED) || (t == `TYPE_COMBINING) || (t == `TYPE_THROUGH) ||
			(t == `TYPE_PROTECTED) || (t == `TYPE_BACK); // R20
	endfunction

	function automatic logic fix_legal(input logic [63:0] d);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 8; i++) begin
			ok = ok && legal_type(d[i*8 +: 8]);
		end
		return ok;
	endfunction

	function automatic logic [35:0] extend(input range_field_type f);
		return {f, `EXT_ZEROS'(0)}; // R7
	endfunction

	function automatic logic write_legal(input logic [7:0] a, input logic [63:0] d);
		logic ok;
		ok = 1'b0;
		if (a == `ADDR_DEFAULT_TYPE) begin
			ok = ((d & `DEF_RSVD_MASK) == `RST_WORD) && legal_type(d[7:0]);
		end else if (is_fix(a)) begin
			ok = fix_legal(d);
		end else if (is_var(a) && !a[0]) begin
			ok = ((d & `BASE_RSVD_MASK) == `RST_WORD) && legal_type(d[7:0]); // R2
		end else if (is_var(a)) begin
			ok = (d & `MASK_RSVD_MASK) == `RST_WORD; // R2
		end
		return ok;
	endfunction

	assign wr_ok = write_legal(reg_addr, reg_wdata);
	assign wr_take = ce && reg_we && wr_ok;
	assign wr_pair = reg_addr[3:1];

	// ****************************************
	// default type control register
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			def_type_q <= `RST_TYPE;
			fixed_range_enable_q <= 1'b0;
			global_enable_q <= 1'b0; // R13
		end else if (wr_take && reg_addr == `ADDR_DEFAULT_TYPE) begin
			def_type_q <= reg_wdata[`TYPE_MSB:`TYPE_LSB];
			fixed_range_enable_q <= reg_wdata[`FIXED_EN_BIT]; // R19
			global_enable_q <= reg_wdata[`ENABLE_BIT]; // R18
		end
	end

	// ****************************************
	// variable pairs
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `PAIR_COUNT; i++) begin
				range_base_field_q[i] <= `RST_FIELD;
				base_type_q[i] <= `RST_TYPE;
				range_mask_field_q[i] <= `RST_FIELD;
			end
			valid_q <= '0; // R13
		end else if (wr_take && is_var(reg_addr)) begin
			if (!reg_addr[0]) begin
				range_base_field_q[wr_pair] <= reg_wdata[`FIELD_MSB:`FIELD_LSB];
				base_type_q[wr_pair] <= reg_wdata[`TYPE_MSB:`TYPE_LSB]; // R17
			end else begin
				range_mask_field_q[wr_pair] <= reg_wdata[`FIELD_MSB:`FIELD_LSB];
				valid_q[wr_pair] <= reg_wdata[`VALID_BIT];
			end
		end
	end

	// ****************************************
	// fault and read path
	// ****************************************
	// a faulting write changes nothing, the whole word is dropped
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_q <= 1'b0;
		end else if (ce) begin
			fault_q <= (reg_we && !wr_ok) || (reg_re && !(reg_addr == `ADDR_DEFAULT_TYPE ||
				is_fix(reg_addr) || is_var(reg_addr))); // R2
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= `RST_WORD;
			fix_sel_q <= 1'b0;
		end else if (ce && reg_re) begin
			fix_sel_q <= is_fix(reg_addr);
			rdata_q <= `RST_WORD;
			if (reg_addr == `ADDR_DEFAULT_TYPE) begin
				rdata_q <= {52'h0, global_enable_q, fixed_range_enable_q, 2'h0, def_type_q};
			end else if (is_var(reg_addr) && !reg_addr[0]) begin
				rdata_q <= {28'h0, range_base_field_q[reg_addr[3:1]], 4'h0,
					base_type_q[reg_addr[3:1]]};
			end else if (is_var(reg_addr)) begin
				rdata_q <= {28'h0, range_mask_field_q[reg_addr[3:1]],
					valid_q[reg_addr[3:1]], 11'h0};
			end
		end
	end

	assign reg_rdata = fix_sel_q ? fix_rdata : rdata_q;
	assign general_protection_fault = fault_q;

	fixed_range_store u_fixed (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.wr_en(wr_take && is_fix(reg_addr)),
		.wr_idx(4'(reg_addr - `ADDR_FIX_FIRST)),
		.wr_data(reg_wdata),
		.rd_en(reg_re),
		.rd_idx(4'(reg_addr - `ADDR_FIX_FIRST)),
		.rd_data(fix_rdata),
		.look_addr(lookup_addr[19:12]),
		.look_type(fix_type)
	);

	// ****************************************
	// lookup
	// ****************************************
	logic [`PAIR_COUNT-1:0] hit;
	logic [`PAIR_COUNT-1:0] hit_unc;
	logic in_fixed;
	logic multi_hit;
	logic [7:0] first_type;

	always_comb begin
		for (int i = 0; i < `PAIR_COUNT; i++) begin
			hit[i] = valid_q[i] && ((lookup_addr & extend(range_mask_field_q[i])) ==
				(extend(range_base_field_q[i]) & extend(range_mask_field_q[i]))); // R1 R16 R21
			hit_unc[i] = hit[i] && (base_type_q[i] == `TYPE_UNCACHED);
		end
	end

	assign in_fixed = fixed_range_enable_q && (lookup_addr[35:20] == 16'h0000);
	assign multi_hit = (hit & (hit - 1'b1)) != '0;

	// other overlaps are undefined: lowest pair wins as a cheap don't-care
	always_comb begin
		first_type = def_type_q;
		for (int i = `PAIR_COUNT - 1; i >= 0; i--) begin
			if (hit[i]) begin
				first_type = base_type_q[i]; // R11 R4
			end
		end
	end

	always_comb begin
		if (!global_enable_q) begin
			lookup_type = def_type_q; // R9
		end else if (in_fixed) begin
			lookup_type = fix_type; // R5 R10
		end else if (hit == '0) begin
			lookup_type = def_type_q; // R12 R6
		end else if (multi_hit && hit_unc != '0) begin
			lookup_type = `TYPE_UNCACHED; // R3
		end else begin
			lookup_type = first_type; // R11
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic [7:0] single_type;
	always_comb begin
		single_type = `RST_TYPE;
		for (int i = 0; i < `PAIR_COUNT; i++) begin
			if (hit[i]) begin
				single_type = base_type_q[i];
			end
		end
	end

	property p_disabled_default;
		!global_enable_q |-> lookup_type == def_type_q;
	endproperty
	a_disabled_default: assert property (p_disabled_default) else $error("disabled not default"); // R9

	property p_fixed_wins;
		global_enable_q && fixed_range_enable_q && lookup_addr[35:20] == 16'h0000
			|-> lookup_type == fix_type;
	endproperty
	a_fixed_wins: assert property (p_fixed_wins) else $error("fixed type not used"); // R10

	property p_invalid_no_hit;
		global_enable_q && !in_fixed && valid_q == '0 |-> lookup_type == def_type_q;
	endproperty
	a_invalid_no_hit: assert property (p_invalid_no_hit) else $error("invalid pair hit"); // R1

	property p_unc_overlap;
		global_enable_q && !in_fixed && multi_hit && hit_unc != '0
			|-> lookup_type == `TYPE_UNCACHED;
	endproperty
	a_unc_overlap: assert property (p_unc_overlap) else $error("overlap not uncached"); // R3

	property p_single_hit;
		global_enable_q && !in_fixed && $onehot(hit) |-> lookup_type == single_type;
	endproperty
	a_single_hit: assert property (p_single_hit) else $error("single hit type wrong"); // R11

	property p_no_hit_default;
		global_enable_q && !in_fixed && hit == '0 |-> lookup_type == def_type_q;
	endproperty
	a_no_hit_default: assert property (p_no_hit_default) else $error("no hit not default"); // R12

	property p_reserved_fault;
		ce && reg_we && is_var(reg_addr) &&
			(reg_wdata & (reg_addr[0] ? `MASK_RSVD_MASK : `BASE_RSVD_MASK)) != `RST_WORD
			|=> general_protection_fault;
	endproperty
	a_reserved_fault: assert property (p_reserved_fault) else $error("no fault on reserved"); // R2

	property p_fault_no_store;
		ce && reg_we && !wr_ok |=> $stable(valid_q) && $stable(global_enable_q);
	endproperty
	a_fault_no_store: assert property (p_fault_no_store) else $error("faulted write stored"); // R2

	property p_enable_readback;
		ce && reg_we && wr_ok && reg_addr == `ADDR_DEFAULT_TYPE ##1 ce && reg_re &&
			reg_addr == `ADDR_DEFAULT_TYPE |=> reg_rdata[11:10] == $past(reg_wdata[11:10], 2);
	endproperty
	a_enable_readback: assert property (p_enable_readback) else $error("enable readback"); // R18

	// software relies on a clean map before it programs anything
	property p_reset_cleared;
		$rose(rst_n) |-> valid_q == '0 && !global_enable_q;
	endproperty
	a_reset_cleared: assert property (p_reset_cleared) else $error("reset left state"); // R13

	property p_base_readback;
		ce && reg_re && is_var(reg_addr) && !reg_addr[0]
			|=> reg_rdata[7:0] == $past(base_type_q[reg_addr[3:1]]);
	endproperty
	a_base_readback: assert property (p_base_readback) else $error("base type readback"); // R17

	property p_valid_readback;
		ce && reg_re && is_var(reg_addr) && reg_addr[0]
			|=> reg_rdata[`VALID_BIT] == $past(valid_q[reg_addr[3:1]]);
	endproperty
	a_valid_readback: assert property (p_valid_readback) else $error("valid readback"); // R1

	// a low clock enable must hold the map even with strobes present
	property p_ce_freeze;
		!ce |=> $stable(valid_q) && $stable(global_enable_q) &&
			$stable(fixed_range_enable_q) && $stable(def_type_q);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("frozen state moved"); // R1 R18

	property p_read_quiet;
		ce && reg_re && (reg_addr == `ADDR_DEFAULT_TYPE || is_fix(reg_addr) || is_var(reg_addr))
			|=> !general_protection_fault;
	endproperty
	a_read_quiet: assert property (p_read_quiet) else $error("legal read faulted"); // R2

	c_fixed: cover property (global_enable_q && in_fixed);
	c_unc_overlap: cover property (global_enable_q && !in_fixed && multi_hit && hit_unc != '0);
	c_freeze: cover property (!ce && reg_we);
	c_single: cover property (global_enable_q && !in_fixed && $onehot(hit));
	c_fault: cover property (general_protection_fault);

endmodule

// File: tb/access_path_model.sv
/*
 * model of the processor access path: presents physical addresses to the
 * resolver and latches the type that it returns.
 * assumes one clock mclk and a resolver that answers in the same cycle.
 */
`timescale 1ns/1ps

module access_path_model (
	input wire logic mclk,
	input wire logic [35:0] req_addr,
	output logic [35:0] lookup_addr,
	input wire logic [7:0] lookup_type,
	output logic [7:0] seen_q
);
	// ****************************************
	// address issue and type capture
	// ****************************************
	// address held level for a whole cycle, so the answer settles before capture
	assign lookup_addr = req_addr;
	always_ff @(posedge mclk) begin
		seen_q <= lookup_type;
	end
endmodule

// File: tb/memory_type_range_resolver_test.sv
/*
 * self-checking bench of the memory type resolver: register bus tasks,
 * lookups through the access path model, one task per scenario.
 * assumes the design package and constants header on the include path.
 */
`timescale 1ns/1ps
`include "memtype_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module memory_type_range_resolver_test;
	logic mclk = 0;
	logic rst_n = 0;
	logic ce = 1;
	logic [7:0] reg_addr = 8'h00;
	logic [63:0] reg_wdata = 64'h0;
	logic reg_we = 0;
	logic reg_re = 0;
	logic [63:0] reg_rdata;
	logic general_protection_fault;
	logic [35:0] req_addr = 36'h0;
	logic [35:0] lookup_addr;
	logic [7:0] lookup_type;
	logic [7:0] seen_q;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [7:0] codes [5] = '{`TYPE_UNCACHED, `TYPE_COMBINING, `TYPE_THROUGH,
		`TYPE_PROTECTED, `TYPE_BACK};

	memtype_resolver DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.general_protection_fault(general_protection_fault), .lookup_addr(lookup_addr),
		.lookup_type(lookup_type));
	access_path_model path (.mclk(mclk), .req_addr(req_addr), .lookup_addr(lookup_addr),
		.lookup_type(lookup_type), .seen_q(seen_q));

	always #25 mclk = ~mclk;

	// ****************************************
	// bus and lookup tasks
	// ****************************************
	task automatic acc(input logic w, input logic [7:0] a, input logic [63:0] d,
		input logic f);
		@(posedge mclk);
		reg_we <= w;
		reg_re <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_we <= 0;
		reg_re <= 0;
		#1;
		`CHK(general_protection_fault, f)
		if (!w && !f) `CHK(reg_rdata, d)
	endtask

	task automatic look(input logic [35:0] a, input logic [7:0] e);
		@(posedge mclk);
		req_addr <= a;
		#1;
		`CHK(lookup_type, e)
		@(posedge mclk);
		#1;
		`CHK(seen_q, e)
	endtask

	task automatic pair(input int n, input logic [23:0] b, input logic [7:0] t,
		input logic [23:0] m, input logic v);
		acc(1, 8'h10 + 8'(2 * n), {28'h0, b, 4'h0, t}, 0);
		acc(1, 8'h11 + 8'(2 * n), {28'h0, m, v, 11'h0}, 0);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		look(36'h0, `TYPE_UNCACHED);
		acc(0, 8'h00, 64'h0, 0);
		acc(0, 8'h11, 64'h0, 0);
		for (int a = 1; a < 32; a++) begin
			if (a < 12 || a > 15) acc(1, 8'(a), 64'h0, 0);
		end
	endtask

	task automatic t_disabled();
		acc(1, 8'h00, 64'h6, 0);
		pair(0, 24'h000200, `TYPE_THROUGH, 24'hfffe00, 1);
		look(36'h200000, `TYPE_BACK);
	endtask

	task automatic t_single();
		acc(1, 8'h00, 64'h806, 0);
		look(36'h200000, `TYPE_THROUGH);
		look(36'h3ff000, `TYPE_THROUGH);
		look(36'h400000, `TYPE_BACK);
		acc(0, 8'h10, {28'h0, 24'h000200, 4'h0, `TYPE_THROUGH}, 0);
		pair(0, 24'h000200, `TYPE_THROUGH, 24'hfffe00, 0);
		look(36'h200000, `TYPE_BACK);
	endtask

	task automatic t_overlap();
		// only uncached and write-back overlap, and five pairs stay unused
		pair(7, 24'h000200, `TYPE_UNCACHED, 24'hfffe00, 1);
		pair(0, 24'h000000, `TYPE_BACK, 24'hfffc00, 1);
		look(36'h200000, `TYPE_UNCACHED);
		pair(3, 24'h000200, `TYPE_UNCACHED, 24'hffff00, 1);
		look(36'h200000, `TYPE_UNCACHED);
		look(36'h100000, `TYPE_BACK);
	endtask

	task automatic t_fixed();
		acc(1, 8'h01, 64'h1, 0);
		acc(1, 8'h02, 64'h400, 0);
		acc(1, 8'h0b, 64'h0500_0000_0000_0000, 0);
		acc(0, 8'h0b, 64'h0500_0000_0000_0000, 0);
		acc(1, 8'h00, 64'hc06, 0);
		look(36'h08000, `TYPE_COMBINING);
		look(36'h10000, `TYPE_UNCACHED);
		look(36'h84000, `TYPE_THROUGH);
		look(36'hff000, `TYPE_PROTECTED);
		acc(1, 8'h00, 64'h806, 0);
		look(36'h08000, `TYPE_BACK);
		acc(1, 8'h00, 64'h406, 0);
		look(36'h08000, `TYPE_BACK);
		acc(1, 8'h00, 64'h806, 0);
	endtask

	task automatic t_bus();
		// write then read with no gap, then a write lost to a low clock enable
		@(posedge mclk);
		reg_we <= 1;
		reg_addr <= 8'h00;
		reg_wdata <= 64'hc04;
		@(posedge mclk);
		reg_we <= 0;
		reg_re <= 1;
		@(posedge mclk);
		reg_re <= 0;
		#1;
		`CHK(reg_rdata, 64'hc04)
		`CHK(general_protection_fault, 1'b0)
		@(posedge mclk);
		ce <= 0;
		reg_we <= 1;
		reg_wdata <= 64'h006;
		@(posedge mclk);
		ce <= 1;
		reg_we <= 0;
		acc(0, 8'h00, 64'hc04, 0);
		acc(1, 8'h00, 64'h806, 0);
	endtask

	task automatic t_fault();
		acc(1, 8'h10, 64'h100, 1);
		acc(1, 8'h11, 64'h1, 1);
		acc(1, 8'h00, 64'h2, 1);
		acc(0, 8'h0c, 64'h0, 1);
		acc(0, 8'h10, {28'h0, 24'h000000, 4'h0, `TYPE_BACK}, 0);
	endtask

	task automatic t_discont();
		pair(7, 24'h0, `TYPE_UNCACHED, 24'h0, 0);
		pair(3, 24'h0, `TYPE_UNCACHED, 24'h0, 0);
		pair(0, 24'h0, `TYPE_UNCACHED, 24'h0, 0);
		pair(1, 24'h000000, `TYPE_THROUGH, 24'hfffdff, 1);
		look(36'h200000, `TYPE_THROUGH);
		look(36'h201000, `TYPE_BACK);
	endtask

	task automatic t_codes();
		foreach (codes[i]) begin
			acc(1, 8'h00, {56'h0, codes[i]}, 0);
			look(36'h300000, codes[i]);
		end
	endtask

	// ****************************************
	// run control
	// ****************************************
	task automatic conclude();
		$display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1;
		t_reset();
		t_disabled();
		t_single();
		t_overlap();
		t_fixed();
		t_bus();
		t_fault();
		t_discont();
		t_codes();
		conclude();
	end

	// limit far above the few hundred cycles the scenarios need
	initial begin
		#500000;
		n_mismatch++;
		conclude();
	end
endmodule
